//--- bench/power_down_mode_state_control_bench.sv
`include "pdm_defs.svh"

module power_down_mode_state_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import pdm_pkg::*;

  // ----------------------------------------
  // signals and scoreboard
  // ----------------------------------------
  typedef struct packed {
    pdm_mode_e   mode;
    logic [11:0] flags;
    pdm_status_s st;
  } pdm_note_s;

  logic        clk_sys_in;
  logic        resetn_in;
  logic        sleep_req;
  logic        tma_tb;
  pdm_bus_s    bus;
  logic [7:0]  rdata;
  logic [11:0] pins;
  logic [11:0] flags;
  pdm_mode_e   mode;
  pdm_status_s status;
  logic        rd_q;
  logic [7:0]  rq [$];
  pdm_note_s   oq [$];
  event        probe_ev;
  int          miscompares;
  int          cmp_count;
  int          seed;
  logic [11:0] exp_flags;

  // ----------------------------------------
  // mode walk: register values, timebase, expected modes
  // ----------------------------------------
  logic [7:0] c_a [8] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h08, 8'h08, 8'h88, 8'h00};
  logic [7:0] c_b [8] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h08};
  logic [7:0] c_t      = 8'h64;  // timebase chosen per case, bit i
  logic [7:0] c_wen    = 8'h6f;  // case ends with a wake, bit i
  pdm_mode_e  c_s [8]  = '{pdm_slp_hi, pdm_slp_med, pdm_watch, pdm_standby,
                           pdm_sub_act, pdm_sub_slp, pdm_watch, pdm_act_hi};
  pdm_mode_e  c_w [8]  = '{pdm_act_hi, pdm_act_med, pdm_act_hi, pdm_act_hi,
                           pdm_sub_act, pdm_sub_act, pdm_sub_act, pdm_act_hi};

  pdm_power_ctrl #(.IRQ_N(12)) u_pdm_power_ctrl (
    .clk_sys_in      (clk_sys_in),
    .resetn_in       (resetn_in),
    .bus_in          (bus),
    .rdata_out       (rdata),
    .sleep_req_in    (sleep_req),
    .tma_timebase_in (tma_tb),
    .ext_irq_pins_in (pins),
    .irq_flags_out   (flags),
    .mode_out        (mode),
    .status_out      (status)
  );

  // 50 mhz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  // ----------------------------------------
  // expected status per mode
  // ----------------------------------------
  function automatic pdm_status_s status_exp(input pdm_mode_e m, input logic t);
    pdm_status_s s;
    s.reduced_power                = (m != pdm_act_hi);
    s.sys_osc_run                  = ~m[2];
    s.sub_osc_run                  = 1'b1;
    s.cpu_run                      = m inside {pdm_act_hi, pdm_act_med, pdm_sub_act};
    s.port_hiz                     = (m == pdm_standby);
    s.timer_a_run                  = ~m[2] | (t & (m != pdm_standby));
    s.timer_v_reset                = m[2];
    s.serial_interface_three_reset = m[2];
    s.pwm_hold                     = (m != pdm_act_hi) && (m != pdm_act_med);
    return s;
  endfunction

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic bus_op(input logic [15:0] a, input logic [7:0] d, input logic w, input logic r);
    @(posedge clk_sys_in);
    bus <= '{addr: a, wdata: d, wr: w, rd: r};
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_op(a, d, 1'b1, 1'b0);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    rq.push_back(e);
    bus_op(a, 8'h00, 1'b0, 1'b1);
  endtask

  task automatic idle();
    bus_op(16'h0000, 8'h00, 1'b0, 1'b0);
  endtask

  task automatic do_sleep();
    @(posedge clk_sys_in);
    sleep_req <= 1'b1;
    @(posedge clk_sys_in);
    sleep_req <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
  endtask

  task automatic pulse(input int k);
    @(posedge clk_sys_in);
    pins[k] <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    pins[k] <= 1'b0;
    repeat (5) @(posedge clk_sys_in);
  endtask

  // note expected mode, flags and status, then wake the monitor
  task automatic chk(input pdm_mode_e m);
    @(negedge clk_sys_in);
    oq.push_back('{mode: m, flags: exp_flags, st: status_exp(m, tma_tb)});
    -> probe_ev;
  endtask

  // ----------------------------------------
  // monitors
  // ----------------------------------------
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // read strobe seen by the design one edge ago
  always @(posedge clk_sys_in) begin
    rd_q <= bus.rd;
  end

  // read data stand in the cycle after the strobe
  always @(negedge clk_sys_in) begin
    if (rd_q === 1'b1) begin
      if (rq.size() == 0) cmp("read queue", 16'h0001, 16'h0000);
      else cmp("rdata", {8'h00, rq.pop_front()}, {8'h00, rdata});
    end
  end

  // mode, flags and status on request
  always @(probe_ev) begin
    pdm_note_s n;
    n = oq.pop_front();
    cmp("mode", {13'h0000, n.mode}, {13'h0000, mode});
    cmp("flags", {4'h0, n.flags}, {4'h0, flags});
    cmp("status", {7'h00, n.st}, {7'h00, status});
  end

  // ----------------------------------------
  // end of run
  // ----------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog well past the expected run length
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    miscompares++;
    complete_run();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] d;
    int         k;
    seed = 32'h5655ed33;
    bus = '0;
    sleep_req = 1'b0;
    tma_tb = 1'b0;
    pins = '0;
    exp_flags = '0;
    miscompares = 0;
    cmp_count = 0;
    resetn_in = 1'b0;
    repeat (10) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    chk(pdm_act_hi);
    rd(`PDM_ADDR_CTRL_A, 8'h07);
    rd(`PDM_ADDR_CTRL_B, 8'he0);
    rd(16'hfff4, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      wr(`PDM_ADDR_CTRL_A, d);
      rd(`PDM_ADDR_CTRL_A, d | 8'h04);
      wr(`PDM_ADDR_CTRL_B, d);
      rd(`PDM_ADDR_CTRL_B, d | 8'he0);
    end
    for (int i = 0; i < 8; i++) begin
      wr(`PDM_ADDR_CTRL_A, c_a[i]);
      wr(`PDM_ADDR_CTRL_B, c_b[i]);
      idle();
      @(posedge clk_sys_in);
      tma_tb <= c_t[i];
      do_sleep();
      chk(c_s[i]);
      // a sleep request in a halted mode must be ignored
      if (!(c_s[i] inside {pdm_act_hi, pdm_sub_act})) begin
        do_sleep();
        chk(c_s[i]);
      end
      if (c_s[i] inside {pdm_watch, pdm_standby}) begin
        k = 1 + ({$random(seed)} % 11);
        pulse(k);
        chk(c_s[i]);
      end
      if (c_wen[i]) begin
        k = (c_s[i] inside {pdm_watch, pdm_standby}) ? 0 : 1 + ({$random(seed)} % 11);
        pulse(k);
        exp_flags[k] = 1'b1;
        chk(c_w[i]);
        rd(`PDM_ADDR_FLAG_LO, exp_flags[7:0]);
        rd(`PDM_ADDR_FLAG_HI, {4'h0, exp_flags[11:8]});
        wr(`PDM_ADDR_FLAG_LO, 8'hff);
        wr(`PDM_ADDR_FLAG_HI, 8'h0f);
        exp_flags = '0;
        rd(`PDM_ADDR_FLAG_LO, 8'h00);
        idle();
      end
    end
    repeat (3) @(posedge clk_sys_in);
    complete_run();
  end

endmodule

//--- core/pdm_defs.svh
`ifndef PDM_DEFS_SVH
`define PDM_DEFS_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define PDM_ADDR_CTRL_A  16'hfff0
`define PDM_ADDR_CTRL_B  16'hfff1
`define PDM_ADDR_FLAG_LO 16'hfff2
`define PDM_ADDR_FLAG_HI 16'hfff3

// ----------------------------------------
// reset values and read-as-one bits
// ----------------------------------------
`define PDM_RST_CTRL_A   8'h07
`define PDM_RST_CTRL_B   8'he0
`define PDM_ONES_CTRL_A  8'h04
`define PDM_ONES_CTRL_B  8'he0
`define PDM_RD_UNMAPPED  8'h00

// ----------------------------------------
// external interrupt lines
// ----------------------------------------
`define PDM_IRQ_COUNT     12
`define PDM_IRQ_HELD_MASK 12'hffe
`define PDM_IRQ_NONE      12'h000

`endif

//--- core/pdm_irq_gate.sv
`include "pdm_defs.svh"

module pdm_irq_gate #(
  parameter int N = `PDM_IRQ_COUNT
) (
  input  wire logic         clk_sys_in,
  input  wire logic         resetn_in,
  input  wire logic [N-1:0] pins_in,
  input  wire logic [N-1:0] held_in,
  input  wire logic [N-1:0] clear_in,
  output logic      [N-1:0] flags_out,
  output logic              taken_out
);
  import pdm_pkg::*;

  logic [N-1:0] sync1;
  logic [N-1:0] sync2;
  logic [N-1:0] prev;
  logic [N-1:0] set_req;

  // two-stage synchroniser, then edge history
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1 <= '0;
      sync2 <= '0;
      prev  <= '0;
    end else begin
      sync1 <= pins_in;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  // rising edges count only on lines not held
  assign set_req = sync2 & ~prev & ~held_in;

  // sticky flags, set beats clear, held lines never set but still cleared by a write of one
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flags_out <= '0;
      taken_out <= 1'b0;
    end else begin
      flags_out <= (flags_out & ~clear_in) | set_req;
      taken_out <= |set_req;
    end
  end

  property p_held_no_wake;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (set_req == '0) |=> !taken_out;
  endproperty
  a_held_no_wake: assert property (p_held_no_wake)
    else $error("wake taken with no accepted request");

  property p_held_flag_kept;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (held_in[1] && !clear_in[1]) |=> (flags_out[1] == $past(flags_out[1]));
  endproperty
  a_held_flag_kept: assert property (p_held_flag_kept)
    else $error("held interrupt flag altered");

endmodule

//--- core/pdm_mode_fsm.sv
`include "pdm_defs.svh"

module pdm_mode_fsm (
  input  wire logic              clk_sys_in,
  input  wire logic              resetn_in,
  input  wire logic              sleep_req_in,
  input  wire logic              wake_in,
  input  wire logic              standby_sel_in,
  input  wire logic              low_speed_in,
  input  wire logic              direct_in,
  input  wire logic              med_speed_in,
  input  wire logic              timebase_in,
  output pdm_pkg::pdm_mode_e     mode_out
);
  import pdm_pkg::*;

  pdm_mode_e next_mode;
  pdm_mode_e act_pick;
  pdm_mode_e slp_pick;

  assign act_pick = med_speed_in ? pdm_act_med : pdm_act_hi;
  assign slp_pick = med_speed_in ? pdm_slp_med : pdm_slp_hi;

  // mode selection from control bits, sleep and wake
  always_comb begin
    next_mode = mode_out;
    unique case (mode_out)
      pdm_act_hi, pdm_act_med: begin
        if (sleep_req_in) begin
          if (direct_in) begin
            next_mode = low_speed_in ? pdm_sub_act : act_pick;
          end else if (!standby_sel_in) begin
            next_mode = slp_pick;
          end else begin
            next_mode = timebase_in ? pdm_watch : pdm_standby;
          end
        end
      end
      pdm_sub_act: begin
        if (sleep_req_in) begin
          if (direct_in && !low_speed_in) begin
            next_mode = act_pick;
          end else if (!standby_sel_in) begin
            next_mode = pdm_sub_slp;
          end else begin
            next_mode = pdm_watch;
          end
        end
      end
      pdm_slp_hi, pdm_slp_med: if (wake_in) next_mode = act_pick;
      pdm_sub_slp: if (wake_in) next_mode = pdm_sub_act;
      pdm_watch: if (wake_in) next_mode = low_speed_in ? pdm_sub_act : act_pick;
      pdm_standby: if (wake_in) next_mode = act_pick;
    endcase
  end

  // mode register
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_out <= pdm_act_hi;
    end else begin
      mode_out <= next_mode;
    end
  end

endmodule

//--- core/pdm_pkg.sv
package pdm_pkg;

  // ----------------------------------------
  // operating modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    pdm_act_hi   = 3'b000,
    pdm_act_med  = 3'b001,
    pdm_slp_hi   = 3'b010,
    pdm_slp_med  = 3'b011,
    pdm_sub_act  = 3'b100,
    pdm_sub_slp  = 3'b101,
    pdm_watch    = 3'b110,
    pdm_standby  = 3'b111
  } pdm_mode_e;

  // ----------------------------------------
  // register layouts
  // ----------------------------------------
  typedef struct packed {
    logic       standby_sel;
    logic [2:0] wait_sel;
    logic       low_speed_wake;
    logic       rsvd;
    logic [1:0] med_clk_sel;
  } pdm_ctrl_a_s;

  typedef struct packed {
    logic [2:0] rsvd;
    logic       noise_sel;
    logic       direct_xfer;
    logic       med_speed;
    logic [1:0] sub_div;
  } pdm_ctrl_b_s;

  // ----------------------------------------
  // bus request and block status
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } pdm_bus_s;

  typedef struct packed {
    logic reduced_power;
    logic sys_osc_run;
    logic sub_osc_run;
    logic cpu_run;
    logic port_hiz;
    logic timer_a_run;
    logic timer_v_reset;
    logic serial_interface_three_reset;
    logic pwm_hold;
  } pdm_status_s;

endpackage

//--- core/pdm_power_ctrl.sv
// The address-and-strobe port is this design's own decision.
`include "pdm_defs.svh"

// How it works
// - Every mode except full-speed active is flagged as a reduced-power mode.
// - In standby the port registers keep their values while the port outputs float.
// - External interrupt lines marked held in the current mode are ignored.
// - Ignored interrupt lines never set their request flags; a write of one still clears them.
// - In watch and the sub modes timer A runs only when its timebase mode is chosen.
// - The operating mode follows the two software-programmed control registers.
// - Control register A sits at 0xfff0, is read/write and resets to 0x07.
// - Control register B sits at 0xfff1, is read/write and resets to 0xe0.
module pdm_power_ctrl #(
  parameter int IRQ_N = `PDM_IRQ_COUNT
) (
  input  wire logic                 clk_sys_in,
  input  wire logic                 resetn_in,
  input  wire pdm_pkg::pdm_bus_s    bus_in,
  output logic [7:0]                rdata_out,
  input  wire logic                 sleep_req_in,
  input  wire logic                 tma_timebase_in,
  input  wire logic [IRQ_N-1:0]     ext_irq_pins_in,
  output logic [IRQ_N-1:0]          irq_flags_out,
  output pdm_pkg::pdm_mode_e        mode_out,
  output pdm_pkg::pdm_status_s      status_out
);
  import pdm_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  pdm_ctrl_a_s      ctrl_a;
  pdm_ctrl_b_s      ctrl_b;
  logic [IRQ_N-1:0] held_mask;
  logic [IRQ_N-1:0] flag_clear;
  logic             wake;
  logic             wr_a;
  logic             wr_b;
  logic             wr_lo;
  logic             wr_hi;
  logic [15:0]      flag_wide;

  // ----------------------------------------
  // address decode
  // ----------------------------------------

  // write strobes per register
  assign wr_a  = bus_in.wr && (bus_in.addr == `PDM_ADDR_CTRL_A);
  assign wr_b  = bus_in.wr && (bus_in.addr == `PDM_ADDR_CTRL_B);
  assign wr_lo = bus_in.wr && (bus_in.addr == `PDM_ADDR_FLAG_LO);
  assign wr_hi = bus_in.wr && (bus_in.addr == `PDM_ADDR_FLAG_HI);

  // ----------------------------------------
  // control registers
  // ----------------------------------------

  // register A, reserved bit forced to one
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_a <= pdm_ctrl_a_s'(`PDM_RST_CTRL_A);
    end else if (wr_a) begin
      ctrl_a <= pdm_ctrl_a_s'(bus_in.wdata | `PDM_ONES_CTRL_A);
    end
  end

  // register B, reserved bits forced to one
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_b <= pdm_ctrl_b_s'(`PDM_RST_CTRL_B);
    end else if (wr_b) begin
      ctrl_b <= pdm_ctrl_b_s'(bus_in.wdata | `PDM_ONES_CTRL_B);
    end
  end

  // ----------------------------------------
  // interrupt flag clear and read view
  // ----------------------------------------

  // write one to clear, low and high bytes
  always_comb begin
    flag_wide = 16'h0000;
    if (wr_lo) begin
      flag_wide[7:0] = bus_in.wdata;
    end
    if (wr_hi) begin
      flag_wide[15:8] = bus_in.wdata;
    end
    flag_clear = flag_wide[IRQ_N-1:0];
  end

  // ----------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= 8'h00;
    end else if (bus_in.rd) begin
      unique case (bus_in.addr)
        `PDM_ADDR_CTRL_A:  rdata_out <= ctrl_a;
        `PDM_ADDR_CTRL_B:  rdata_out <= ctrl_b;
        `PDM_ADDR_FLAG_LO: rdata_out <= 8'(irq_flags_out);
        `PDM_ADDR_FLAG_HI: rdata_out <= 8'({4'h0, irq_flags_out} >> 8);
        default:           rdata_out <= `PDM_RD_UNMAPPED;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ----------------------------------------
  // interrupt hold per mode
  // ----------------------------------------

  // watch and standby ignore all lines but the first
  assign held_mask = (mode_out == pdm_watch || mode_out == pdm_standby) ?
                     IRQ_N'(`PDM_IRQ_HELD_MASK) : IRQ_N'(`PDM_IRQ_NONE);

  pdm_irq_gate #(
    .N (IRQ_N)
  ) u_irq (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .pins_in    (ext_irq_pins_in),
    .held_in    (held_mask),
    .clear_in   (flag_clear),
    .flags_out  (irq_flags_out),
    .taken_out  (wake)
  );

  // ----------------------------------------
  // mode sequencer
  // ----------------------------------------
  pdm_mode_fsm u_fsm (
    .clk_sys_in     (clk_sys_in),
    .resetn_in      (resetn_in),
    .sleep_req_in   (sleep_req_in),
    .wake_in        (wake),
    .standby_sel_in (ctrl_a.standby_sel),
    .low_speed_in   (ctrl_a.low_speed_wake),
    .direct_in      (ctrl_b.direct_xfer),
    .med_speed_in   (ctrl_b.med_speed),
    .timebase_in    (tma_timebase_in),
    .mode_out       (mode_out)
  );

  // ----------------------------------------
  // per-mode internal state
  // ----------------------------------------

  // status decode, registered one cycle behind the mode
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status_out <= '0;
    end else begin
      status_out.reduced_power <= (mode_out != pdm_act_hi);
      status_out.sys_osc_run <= (mode_out < pdm_sub_act);
      status_out.sub_osc_run <= 1'b1;
      status_out.cpu_run <= (mode_out == pdm_act_hi) || (mode_out == pdm_act_med) ||
                            (mode_out == pdm_sub_act);
      status_out.port_hiz <= (mode_out == pdm_standby);
      if (mode_out == pdm_standby) begin
        status_out.timer_a_run <= 1'b0;
      end else if (mode_out >= pdm_sub_act) begin
        status_out.timer_a_run <= tma_timebase_in;
      end else begin
        status_out.timer_a_run <= 1'b1;
      end
      status_out.timer_v_reset <= (mode_out >= pdm_sub_act);
      status_out.serial_interface_three_reset <= (mode_out >= pdm_sub_act);
      status_out.pwm_hold <= (mode_out != pdm_act_hi) && (mode_out != pdm_act_med);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_reduced;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    ##1 status_out.reduced_power == ($past(mode_out) != pdm_act_hi);
  endproperty
  a_reduced: assert property (p_reduced)
    else $error("reduced power flag wrong for mode");

  property p_port_hiz;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (mode_out == pdm_standby) |=> status_out.port_hiz;
  endproperty
  a_port_hiz: assert property (p_port_hiz)
    else $error("ports not floating in standby");

  property p_irq_held;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (mode_out == pdm_standby) |-> (held_mask[IRQ_N-1:1] == '1) && !held_mask[0];
  endproperty
  a_irq_held: assert property (p_irq_held)
    else $error("standby hold mask wrong");

  property p_timer_a;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (mode_out == pdm_watch || mode_out == pdm_sub_act || mode_out == pdm_sub_slp)
      |=> (status_out.timer_a_run == $past(tma_timebase_in));
  endproperty
  a_timer_a: assert property (p_timer_a)
    else $error("timer A run does not follow timebase select");

  property p_to_standby;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (mode_out == pdm_act_hi && sleep_req_in && ctrl_a.standby_sel &&
     !ctrl_b.direct_xfer && !tma_timebase_in)
      |=> (mode_out == pdm_standby);
  endproperty
  a_to_standby: assert property (p_to_standby)
    else $error("standby not entered on sleep");

  property p_to_sleep;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (mode_out == pdm_act_hi && sleep_req_in && !ctrl_a.standby_sel &&
     !ctrl_b.direct_xfer && ctrl_b.med_speed)
      |=> (mode_out == pdm_slp_med);
  endproperty
  a_to_sleep: assert property (p_to_sleep)
    else $error("medium sleep not entered on sleep");

  property p_read_a;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (wr_a ##1 (bus_in.rd && bus_in.addr == `PDM_ADDR_CTRL_A && !bus_in.wr))
      |=> (rdata_out == ($past(bus_in.wdata, 2) | `PDM_ONES_CTRL_A));
  endproperty
  a_read_a: assert property (p_read_a)
    else $error("register A readback wrong");

  property p_read_b;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (wr_b ##1 (bus_in.rd && bus_in.addr == `PDM_ADDR_CTRL_B && !bus_in.wr))
      |=> (rdata_out == ($past(bus_in.wdata, 2) | `PDM_ONES_CTRL_B));
  endproperty
  a_read_b: assert property (p_read_b)
    else $error("register B readback wrong");

  property p_cpu_osc;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (mode_out == pdm_watch || mode_out == pdm_sub_slp)
      |=> !status_out.cpu_run && !status_out.sys_osc_run && status_out.sub_osc_run;
  endproperty
  a_cpu_osc: assert property (p_cpu_osc)
    else $error("cpu or oscillator state wrong");

  property p_periph_reset;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (mode_out == pdm_slp_hi) |=> status_out.pwm_hold && !status_out.timer_v_reset &&
                                 !status_out.serial_interface_three_reset;
  endproperty
  a_periph_reset: assert property (p_periph_reset)
    else $error("peripheral hold or reset wrong in sleep");

  property p_standby_periph;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (mode_out == pdm_standby)
      |=> status_out.timer_v_reset && status_out.serial_interface_three_reset &&
          status_out.pwm_hold && !status_out.timer_a_run && !status_out.cpu_run;
  endproperty
  a_standby_periph: assert property (p_standby_periph)
    else $error("peripheral state wrong in standby");

  property p_sleep_ignored;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (sleep_req_in && !wake && (mode_out == pdm_slp_hi || mode_out == pdm_slp_med ||
     mode_out == pdm_sub_slp || mode_out == pdm_watch || mode_out == pdm_standby))
      |=> (mode_out == $past(mode_out));
  endproperty
  a_sleep_ignored: assert property (p_sleep_ignored)
    else $error("sleep request acted on outside a running mode");

  property p_wake_watch;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (mode_out == pdm_watch && wake && ctrl_a.low_speed_wake) |=> (mode_out == pdm_sub_act);
  endproperty
  a_wake_watch: assert property (p_wake_watch)
    else $error("watch wake did not reach subactive");

  property p_held_no_set;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    (mode_out == pdm_watch || mode_out == pdm_standby)
      |=> ((irq_flags_out[IRQ_N-1:1] & ~$past(irq_flags_out[IRQ_N-1:1])) == '0);
  endproperty
  a_held_no_set: assert property (p_held_no_set)
    else $error("held interrupt line raised its flag");

  property p_rd_idle;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    !bus_in.rd |=> (rdata_out == 8'h00);
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not cleared after the read cycle");

  property p_to_sub;
    @(posedge clk_sys_in) disable iff (!resetn_in)
    ((mode_out == pdm_act_hi || mode_out == pdm_act_med) && sleep_req_in &&
     ctrl_b.direct_xfer && ctrl_a.low_speed_wake)
      |=> (mode_out == pdm_sub_act);
  endproperty
  a_to_sub: assert property (p_to_sub)
    else $error("direct transfer to subactive missed");

endmodule
